// >>> hdl/bpa_arbiter.sv
// Design decisions made here: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
module bpa_arbiter
  import bpa_pkg::*;
#(
  parameter int N_DEV = 4
) (
  input  wire logic        CLK_SYS,
  input  wire logic        RESET,
  bpa_if.arbiter           BUS,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  output logic             IRQ
);
  // ****************************************
  // pin synchronisers (3 stages)
  // ****************************************
  logic [NUM_CLASS-1:0] req_s1 [N_DEV];
  logic [NUM_CLASS-1:0] req_s2 [N_DEV];
  logic [NUM_CLASS-1:0] req_s3 [N_DEV];
  logic [N_DEV-1:0]     busy_s1, busy_s2, busy_s3;
  logic [N_DEV-1:0]     msyn_s1, msyn_s2, msyn_s3;
  logic [NUM_CLASS-1:0] req_q [N_DEV];
  logic [N_DEV-1:0]     busy_q, msyn_q;
  genvar g;
  generate
    for (g = 0; g < N_DEV; g++) begin : g_sync
      always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
          req_s1[g]  <= '0;
          req_s2[g]  <= '0;
          req_s3[g]  <= '0;
          req_q[g]   <= '0;
          busy_s1[g] <= 1'b0;
          busy_s2[g] <= 1'b0;
          busy_s3[g] <= 1'b0;
          busy_q[g]  <= 1'b0;
          msyn_s1[g] <= 1'b0;
          msyn_s2[g] <= 1'b0;
          msyn_s3[g] <= 1'b0;
          msyn_q[g]  <= 1'b0;
        end else begin
          req_s1[g]  <= BUS.req[g];
          req_s2[g]  <= req_s1[g];
          req_s3[g]  <= req_s2[g];
          busy_s1[g] <= BUS.bus_busy[g];
          busy_s2[g] <= busy_s1[g];
          busy_s3[g] <= busy_s2[g];
          msyn_s1[g] <= BUS.msyn[g];
          msyn_s2[g] <= msyn_s1[g];
          msyn_s3[g] <= msyn_s2[g];
          for (int c = 0; c < NUM_CLASS; c++) begin
            if (req_s2[g][c] == req_s3[g][c]) begin
              req_q[g][c] <= req_s3[g][c];
            end
          end
          if (busy_s2[g] == busy_s3[g]) begin
            busy_q[g] <= busy_s3[g];
          end
          if (msyn_s2[g] == msyn_s3[g]) begin
            msyn_q[g] <= msyn_s3[g];
          end
        end
      end
    end
  endgenerate
  // ****************************************
  // registers
  // ****************************************
  logic [15:0]    psw_r;
  logic [5:0]     ctrl_r;
  logic [15:0]    result_r;
  logic [EV_W-1:0] status_r, mask_r;
  logic           trace_armed_r;
  logic [2:0]     pri;
  assign pri = psw_r[PSW_PRI_MSB:PSW_PRI_LSB];
  // ****************************************
  // class selection
  // ****************************************
  logic [NUM_CLASS-1:0] cls_any;
  logic [NUM_CLASS-1:0] cls_ok;
  always_comb begin
    cls_any = '0;
    for (int d = 0; d < N_DEV; d++) begin
      cls_any = cls_any | req_q[d];
    end
  end
  // class index 4 = npr, 3..0 = levels 7..4
  logic instr_end, in_rmw;
  assign instr_end = ctrl_r[CTRL_INSTR_END];
  assign in_rmw    = ctrl_r[CTRL_RMW];
  generate
    for (g = 0; g < NUM_CLASS - 1; g++) begin : g_lvl
      // level g+4 granted only above priority, only between instructions
      assign cls_ok[g] = cls_any[g] && (3'(g + 4) > pri) && instr_end && !in_rmw;
    end
  endgenerate
  assign cls_ok[CLS_NPR] = cls_any[CLS_NPR] && !in_rmw;
  logic [NUM_CLASS-1:0] cls_rev, cls_pick_rev;
  logic                 cls_hit;
  always_comb begin
    for (int i = 0; i < NUM_CLASS; i++) begin
      cls_rev[i] = cls_ok[NUM_CLASS-1-i];
    end
  end
  bpa_pick #(.N(NUM_CLASS)) u_cls (
    .req    (cls_rev),
    .onehot (cls_pick_rev),
    .any    (cls_hit)
  );
  logic [NUM_CLASS-1:0] win_cls;
  always_comb begin
    for (int i = 0; i < NUM_CLASS; i++) begin
      win_cls[i] = cls_pick_rev[NUM_CLASS-1-i];
    end
  end
  logic [N_DEV-1:0] dev_req, dev_pick;
  always_comb begin
    for (int d = 0; d < N_DEV; d++) begin
      dev_req[d] = |(req_q[d] & win_cls);
    end
  end
  bpa_pick #(.N(N_DEV)) u_dev (
    .req    (dev_req),
    .onehot (dev_pick),
    .any    ()
  );
  // ****************************************
  // grant state machine
  // ****************************************
  bpa_arb_e          state_r;
  logic [N_DEV-1:0]  grant_r;
  logic [7:0]        gap_r;
  logic              ssyn_r;
  logic              grant_ev;
  assign grant_ev  = (state_r == ARB_IDLE) && cls_hit;
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      state_r <= ARB_IDLE;
      grant_r <= '0;
      gap_r   <= '0;
    end else begin
      case (state_r)
        ARB_IDLE: begin
          if (cls_hit) begin
            grant_r <= dev_pick;
            state_r <= ARB_GRANT;
          end
        end
        ARB_GRANT: begin
          if (|(busy_q & grant_r)) begin
            grant_r <= '0;
            state_r <= ARB_BUSY;
          end
        end
        ARB_BUSY: begin
          if (busy_q == '0) begin
            gap_r   <= 8'(XFER_GAP_CYCLES);
            state_r <= ARB_GAP;
          end
        end
        ARB_GAP: begin
          if (gap_r <= 8'h01) begin
            state_r <= ARB_IDLE;
          end else begin
            gap_r <= gap_r - 8'h01;
          end
        end
        default: state_r <= ARB_IDLE;
      endcase
    end
  end
  // master owning the bus keeps its busy; slave reply interlocked on msyn
  logic [N_DEV-1:0] owner_r;
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      owner_r <= '0;
    end else if (state_r == ARB_GRANT && |(busy_q & grant_r)) begin
      owner_r <= grant_r;
    end else if (busy_q == '0) begin
      owner_r <= '0;
    end
  end
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      ssyn_r <= 1'b0;
    end else begin
      ssyn_r <= |(msyn_q & owner_r);
    end
  end
  assign BUS.grant = grant_r;
  assign BUS.ssyn  = ssyn_r;
  assign BUS.rdata = psw_r;
  // ****************************************
  // wishbone slave and status word
  // ****************************************
  logic wb_hit, wb_wr, wb_rd_status;
  assign wb_hit       = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign wb_wr        = wb_hit && WB_WE_I;
  assign wb_rd_status = wb_hit && !WB_WE_I && (WB_ADR_I == REG_STATUS);
  logic ctrl_wr;
  assign ctrl_wr = wb_wr && (WB_ADR_I == REG_CTRL) && WB_SEL_I[0];
  logic [15:0] res;
  assign res = result_r;
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      psw_r <= PSW_RESET;
    end else if (wb_wr && WB_ADR_I == REG_PSW && WB_SEL_I[0]) begin
      psw_r <= {8'h00, WB_DAT_I[7:0]} & PSW_MASK;
    end else if (ctrl_wr && WB_DAT_I[CTRL_RES_VALID]) begin
      psw_r[PSW_Z_BIT] <= (res == 16'h0000);
      psw_r[PSW_N_BIT] <= res[15];
      psw_r[PSW_C_BIT] <= WB_DAT_I[CTRL_RES_CARRY];
      psw_r[PSW_V_BIT] <= WB_DAT_I[CTRL_RES_OVF];
    end
  end
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      ctrl_r   <= '0;
      result_r <= '0;
      mask_r   <= '0;
    end else begin
      if (ctrl_wr) begin
        ctrl_r <= WB_DAT_I[5:0];
      end
      if (wb_wr && WB_ADR_I == REG_RESULT) begin
        result_r <= WB_DAT_I[15:0];
      end
      if (wb_wr && WB_ADR_I == REG_MASK) begin
        mask_r <= WB_DAT_I[EV_W-1:0];
      end
    end
  end
  // trace armed at fetch, trap raised when the instruction ends
  logic trap_ev;
  assign trap_ev = ctrl_wr && WB_DAT_I[CTRL_INSTR_END] && trace_armed_r;
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      trace_armed_r <= 1'b0;
    end else if (ctrl_wr && WB_DAT_I[CTRL_FETCH]) begin
      trace_armed_r <= psw_r[PSW_T_BIT];
    end else if (trap_ev) begin
      trace_armed_r <= 1'b0;
    end
  end
  logic [EV_W-1:0] ev;
  assign ev = {trap_ev, grant_ev};
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      status_r <= '0;
    end else begin
      // set beats a read-clear in the same cycle
      status_r <= (wb_rd_status ? '0 : status_r) | ev;
    end
  end
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(status_r & mask_r);
    end
  end
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= '0;
    end else begin
      WB_ACK_O <= wb_hit;
      case (WB_ADR_I)
        REG_PSW:    WB_DAT_O <= {16'h0000, psw_r};
        REG_CTRL:   WB_DAT_O <= {26'h0, ctrl_r};
        REG_RESULT: WB_DAT_O <= {16'h0000, result_r};
        REG_GRANT:  WB_DAT_O <= {22'h0, 2'(state_r), 8'(grant_r)};
        REG_STATUS: WB_DAT_O <= {30'h0, status_r};
        REG_MASK:   WB_DAT_O <= {30'h0, mask_r};
        default:    WB_DAT_O <= 32'h0000_0000;
      endcase
    end
  end
endmodule : bpa_arbiter

// >>> common/bpa_pkg.sv
package bpa_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS   = 10;
  localparam int XFER_MIN_NS     = 750;
  localparam int XFER_GAP_CYCLES = (XFER_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ****************************************
  // status word layout
  // ****************************************
  localparam int PSW_C_BIT       = 0;
  localparam int PSW_V_BIT       = 1;
  localparam int PSW_Z_BIT       = 2;
  localparam int PSW_N_BIT       = 3;
  localparam int PSW_T_BIT       = 4;
  localparam int PSW_PRI_LSB     = 5;
  localparam int PSW_PRI_MSB     = 7;
  localparam logic [15:0] PSW_RESET = 16'h00E0;
  localparam logic [15:0] PSW_MASK  = 16'h00FF;
  // ****************************************
  // address space
  // ****************************************
  localparam int ADDR_W          = 16;
  localparam logic [15:0] IO_BASE = 16'hE000;
  // ****************************************
  // controller register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] REG_PSW    = 8'h00;
  localparam logic [7:0] REG_CTRL   = 8'h04;
  localparam logic [7:0] REG_RESULT = 8'h08;
  localparam logic [7:0] REG_GRANT  = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_MASK   = 8'h14;
  localparam int CTRL_INSTR_END  = 0;
  localparam int CTRL_FETCH      = 1;
  localparam int CTRL_RMW        = 2;
  localparam int CTRL_RES_VALID  = 3;
  localparam int CTRL_RES_CARRY  = 4;
  localparam int CTRL_RES_OVF    = 5;
  localparam int EV_GRANT        = 0;
  localparam int EV_TRAP         = 1;
  localparam int EV_W            = 2;
  // ****************************************
  // request classes
  // ****************************************
  localparam int NUM_CLASS       = 5;
  localparam int CLS_NPR         = 4;
  typedef enum logic [1:0] {ARB_IDLE = 2'b00, ARB_GRANT = 2'b01, ARB_BUSY = 2'b11,
                            ARB_GAP = 2'b10} bpa_arb_e;
endpackage : bpa_pkg

// >>> common/bpa_if.sv
`timescale 1ns/1ps
interface bpa_if #(parameter int N_DEV = 4);
  import bpa_pkg::*;
  logic [NUM_CLASS-1:0] req    [N_DEV];
  logic [N_DEV-1:0]     grant;
  logic                 bus_busy [N_DEV];
  logic                 msyn   [N_DEV];
  logic                 ssyn;
  logic [ADDR_W-1:0]    addr   [N_DEV];
  logic                 we     [N_DEV];
  logic                 byte_x [N_DEV];
  logic [15:0]          wdata  [N_DEV];
  logic [15:0]          rdata;
  modport arbiter (input req, input bus_busy, input msyn, output grant, output ssyn, output rdata);
  modport requester (output req, output bus_busy, output msyn, output addr, output we,
                     output byte_x, output wdata, input grant, input ssyn, input rdata);
endinterface : bpa_if

// >>> hdl/bpa_pick.sv
`timescale 1ns/1ps
module bpa_pick #(
  parameter int N = 4
) (
  input  wire logic [N-1:0] req,
  output logic      [N-1:0] onehot,
  output logic              any
);
  // lowest index = electrically nearest wins
  always_comb begin
    onehot = '0;
    any    = 1'b0;
    for (int i = 0; i < N; i++) begin
      if (req[i] && !any) begin
        onehot[i] = 1'b1;
        any       = 1'b1;
      end
    end
  end
endmodule : bpa_pick

// >>> hdl/bpa_requester.sv
`timescale 1ns/1ps
module bpa_requester
  import bpa_pkg::*;
#(
  parameter int IDX   = 0,
  parameter int N_DEV = 4
) (
  input  wire logic                 CLK_SYS,
  input  wire logic                 RESET,
  bpa_if.requester                  BUS,
  input  wire logic [NUM_CLASS-1:0] REQ_CLASS,
  input  wire logic                 GO,
  input  wire logic [ADDR_W-1:0]    ADDR,
  input  wire logic                 WE,
  input  wire logic                 BYTE_MODE,
  input  wire logic [15:0]          WDATA,
  output logic      [15:0]          RDATA,
  output logic                      DONE,
  output logic                      BUSY
);
  // ****************************************
  // grant and reply synchronisers
  // ****************************************
  logic g1, g2, g3, gq, s1, s2, s3, sq;
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      {g1, g2, g3, gq, s1, s2, s3, sq} <= '0;
    end else begin
      g1 <= BUS.grant[IDX];
      g2 <= g1;
      g3 <= g2;
      s1 <= BUS.ssyn;
      s2 <= s1;
      s3 <= s2;
      if (g2 == g3) begin
        gq <= g3;
      end
      if (s2 == s3) begin
        sq <= s3;
      end
    end
  end
  // ****************************************
  // master sequence
  // ****************************************
  logic [NUM_CLASS-1:0] req_r;
  logic busy_r, msyn_r;
  logic [1:0] ph_r;
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      req_r  <= '0;
      busy_r <= 1'b0;
      msyn_r <= 1'b0;
      ph_r   <= 2'h0;
      DONE   <= 1'b0;
      RDATA  <= '0;
    end else begin
      DONE <= 1'b0;
      case (ph_r)
        2'h0: if (GO) begin
          req_r <= REQ_CLASS;
          ph_r  <= 2'h1;
        end
        2'h1: if (gq) begin
          req_r  <= '0;
          busy_r <= 1'b1;
          msyn_r <= 1'b1;
          ph_r   <= 2'h3;
        end
        2'h3: if (sq) begin
          msyn_r <= 1'b0;
          RDATA  <= BUS.rdata;
          ph_r   <= 2'h2;
        end
        2'h2: if (!sq) begin
          busy_r <= 1'b0;
          DONE   <= 1'b1;
          ph_r   <= 2'h0;
        end
        default: ph_r <= 2'h0;
      endcase
    end
  end
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      BUSY <= 1'b0;
    end else begin
      BUSY <= (ph_r != 2'h0) || GO;
    end
  end
  assign BUS.req[IDX]      = req_r;
  assign BUS.bus_busy[IDX] = busy_r;
  assign BUS.msyn[IDX]     = msyn_r;
  assign BUS.addr[IDX]     = ADDR;
  assign BUS.we[IDX]       = WE;
  assign BUS.byte_x[IDX]   = BYTE_MODE;
  assign BUS.wdata[IDX]    = WDATA;
endmodule : bpa_requester

// >>> test/bpa_props.sv
`timescale 1ns/1ps
module bpa_props
  import bpa_pkg::*;
#(
  parameter int N_DEV = 4
) (
  input wire logic             CLK_SYS,
  input wire logic             RESET,
  input wire logic [N_DEV-1:0] grant,
  input wire logic             bus_busy [N_DEV],
  input wire logic             msyn     [N_DEV],
  input wire logic             ssyn
);
  // ****************************************
  // helpers
  // ****************************************
  logic [N_DEV-1:0] busy_v;
  logic [N_DEV-1:0] msyn_v;
  logic [7:0]       idle_r;
  always_comb begin
    for (int d = 0; d < N_DEV; d++) begin
      busy_v[d] = bus_busy[d];
      msyn_v[d] = msyn[d];
    end
  end
  // saturates, so the first grant after reset owes no gap
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      idle_r <= 8'hFF;
    end else if (|busy_v) begin
      idle_r <= 8'h00;
    end else if (idle_r != 8'hFF) begin
      idle_r <= idle_r + 8'h01;
    end
  end
  default clocking @(posedge CLK_SYS);
  endclocking
  default disable iff (RESET);
  // ****************************************
  // properties
  // ****************************************
  a_one_grant: assert property ($onehot0(grant))
    else $error("more than one grant");
  a_one_master: assert property ($onehot0(busy_v))
    else $error("two masters own the bus");
  a_grant_idle_bus: assert property ($rose(|grant) |-> busy_v == '0)
    else $error("grant while bus owned");
  a_grant_stands: assert property ((|grant) && busy_v == '0 |=> grant == $past(grant))
    else $error("grant changed before takeover");
  a_gap_kept: assert property ($rose(|grant) |-> idle_r >= XFER_GAP_CYCLES - 1)
    else $error("grant too soon after release");
  a_owner_granted: assert property ($rose(|busy_v) |-> $past(|grant))
    else $error("bus taken without grant");
  a_strobe_owner: assert property ((msyn_v & ~busy_v) == '0)
    else $error("strobe from non-owner");
  a_reply_needs_strobe: assert property ($rose(ssyn) |-> |msyn_v)
    else $error("reply without strobe");
  a_reply_comes: assert property ($rose(|msyn_v) |-> ##[1:20] ssyn)
    else $error("strobe not answered");
  a_reply_ends: assert property ($fell(|msyn_v) |-> ##[0:8] !ssyn)
    else $error("reply held after strobe");
endmodule : bpa_props

// >>> test/bus_priority_arbiter_test.sv
`timescale 1ns/1ps
module bus_priority_arbiter_test;
  import bpa_pkg::*;
  logic        CLK_SYS   = 1'b0;
  logic        RESET     = 1'b1;
  logic        wb_cyc    = 1'b0;
  logic        wb_stb    = 1'b0;
  logic        wb_we     = 1'b0;
  logic [7:0]  wb_adr    = 8'h00;
  logic [31:0] wb_dat_w  = 32'h0;
  logic [3:0]  wb_sel    = 4'h0;
  logic [3:0]  sel_use   = 4'h1;
  logic [31:0] wb_dat_r;
  logic        wb_ack;
  logic        irq;
  logic [4:0]  req_class [2] = '{5'h00, 5'h00};
  logic        go        [2] = '{1'b0, 1'b0};
  logic [15:0] xa        = IO_BASE;
  logic        xwe       = 1'b0;
  logic        xbyte     = 1'b0;
  logic [15:0] xwd       = 16'h0000;
  logic [15:0] rdata     [2];
  logic        done      [2];
  logic        busy      [2];
  logic [31:0] rd;
  int          num_errors  = 0;
  int          check_count = 0;
  int          cycles      = 0;
  int          n_done      = 0;
  int          exp_done    = 0;
  always #5 CLK_SYS = ~CLK_SYS;
  bpa_if #(.N_DEV(2)) bus ();
  bpa_arbiter #(.N_DEV(2)) bpa_arbiter_inst (.CLK_SYS(CLK_SYS), .RESET(RESET), .BUS(bus),
    .WB_CYC_I(wb_cyc), .WB_STB_I(wb_stb), .WB_WE_I(wb_we), .WB_ADR_I(wb_adr), .WB_SEL_I(wb_sel),
    .WB_DAT_I(wb_dat_w), .WB_DAT_O(wb_dat_r), .WB_ACK_O(wb_ack), .IRQ(irq));
  for (genvar d = 0; d < 2; d++) begin : g_req
    bpa_requester #(.IDX(d), .N_DEV(2)) bpa_requester_inst (.CLK_SYS(CLK_SYS), .RESET(RESET),
      .BUS(bus), .REQ_CLASS(req_class[d]), .GO(go[d]), .ADDR(xa), .WE(xwe), .BYTE_MODE(xbyte),
      .WDATA(xwd), .RDATA(rdata[d]), .DONE(done[d]), .BUSY(busy[d]));
  end
  bpa_props #(.N_DEV(2)) bpa_props_inst (.CLK_SYS(CLK_SYS), .RESET(RESET), .grant(bus.grant),
    .bus_busy(bus.bus_busy), .msyn(bus.msyn), .ssyn(bus.ssyn));
  // ****************************************
  // tasks
  // ****************************************
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    wb_cyc   <= 1'b1;
    wb_stb   <= 1'b1;
    wb_we    <= w;
    wb_sel   <= sel_use;
    wb_adr   <= a;
    wb_dat_w <= d;
    do @(posedge CLK_SYS); while (wb_ack !== 1'b1);
    rd = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_sel <= 4'h0;
    @(posedge CLK_SYS);
  endtask : wb
  task automatic rchk(input string what, input logic [7:0] a, input logic [15:0] exp);
    wb(1'b0, a, 32'h0);
    check(what, rd[15:0], exp);
  endtask : rchk
  // each start call moves a different address, direction and width, shared by both requesters
  task automatic start(input logic [4:0] c0, input logic [4:0] c1);
    req_class[0] <= c0;
    req_class[1] <= c1;
    go[0]        <= |c0;
    go[1]        <= |c1;
    xa           <= xa + 16'h0002;
    xwe          <= ~xwe;
    xbyte        <= xwe;
    xwd          <= xwd + 16'h0101;
    exp_done     += int'(|c0) + int'(|c1);
    @(posedge CLK_SYS);
    go[0] <= 1'b0;
    go[1] <= 1'b0;
  endtask : start
  task automatic first_grant(input string what, input logic [1:0] exp);
    while (bus.grant === 2'b00) @(posedge CLK_SYS);
    check(what, 16'(bus.grant), 16'(exp));
    while (n_done < exp_done) @(posedge CLK_SYS);
  endtask : first_grant
  task automatic expect_none(input string what);
    logic seen;
    seen = 1'b0;
    repeat (100) begin
      @(posedge CLK_SYS);
      seen = seen | (bus.grant !== 2'b00);
    end
    check(what, 16'(seen), 16'h0000);
  endtask : expect_none
  always @(posedge CLK_SYS) begin
    n_done <= n_done + int'(done[0] === 1'b1) + int'(done[1] === 1'b1);
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end
  // ****************************************
  // sequence
  // ****************************************
  initial begin
    repeat (6) @(posedge CLK_SYS);
    RESET <= 1'b0;
    @(posedge CLK_SYS);
    rchk("psw reset", REG_PSW, 16'h00E0);
    check("irq reset", 16'(irq), 16'h0000);
    rchk("grant reset", REG_GRANT, 16'h0000);
    wb(1'b1, 8'h3C, 32'hFFFF_FFFF);
    rchk("unmapped", 8'h3C, 16'h0000);
    // low lane off: status word write must be ignored
    sel_use = 4'h0;
    wb(1'b1, REG_PSW, 32'h0000_0000);
    sel_use = 4'h1;
    rchk("psw lane off", REG_PSW, 16'h00E0);
    wb(1'b1, REG_PSW, 32'h0000_00A0);
    wb(1'b1, REG_RESULT, 32'h0000_0000);
    wb(1'b1, REG_CTRL, 32'h0000_0019);
    rchk("zero carry", REG_PSW, 16'h00A5);
    wb(1'b1, REG_RESULT, 32'h0000_8000);
    wb(1'b1, REG_CTRL, 32'h0000_0029);
    rchk("neg ovf", REG_PSW, 16'h00AA);
    rchk("ctrl back", REG_CTRL, 16'h0029);
    rchk("result back", REG_RESULT, 16'h8000);
    wb(1'b1, REG_MASK, 32'h0000_0002);
    rchk("mask back", REG_MASK, 16'h0002);
    wb(1'b0, REG_STATUS, 32'h0);
    for (int t = 0; t < 2; t++) begin
      wb(1'b1, REG_PSW, 32'(t << 4));
      wb(1'b1, REG_CTRL, 32'h0000_0002);
      wb(1'b1, REG_CTRL, 32'h0000_0001);
      repeat (2) @(posedge CLK_SYS);
      check("trap irq", 16'(irq), 16'(t));
      rchk("trap status", REG_STATUS, 16'(t << 1));
    end
    $display("registers and flags done");
    wb(1'b1, REG_PSW, 32'h0000_0000);
    wb(1'b1, REG_CTRL, 32'h0000_0000);
    start(5'h10, 5'h00);
    first_grant("npr mid instr", 2'b01);
    check("busy idle", 16'(busy[0]), 16'h0000);
    start(5'h01, 5'h00);
    expect_none("level mid instr");
    check("busy pending", 16'(busy[0]), 16'h0001);
    wb(1'b1, REG_CTRL, 32'h0000_0001);
    first_grant("level at end", 2'b01);
    for (int lvl = 7; lvl >= 4; lvl--) begin
      wb(1'b1, REG_PSW, 32'(lvl << 5));
      start(5'(1 << (lvl - 4)), 5'h00);
      expect_none("level at pri");
      wb(1'b1, REG_PSW, 32'((lvl - 1) << 5));
      first_grant("level over pri", 2'b01);
      check("level rdata", rdata[0], 16'((lvl - 1) << 5));
    end
    $display("priority levels done");
    start(5'h08, 5'h10);
    first_grant("npr over top level", 2'b10);
    start(5'h04, 5'h04);
    first_grant("nearer wins", 2'b01);
    wb(1'b1, REG_CTRL, 32'h0000_0005);
    start(5'h00, 5'h10);
    expect_none("rmw hold");
    rchk("grant idle", REG_GRANT, 16'h0000);
    wb(1'b1, REG_CTRL, 32'h0000_0001);
    first_grant("after rmw", 2'b10);
    $display("arbitration done");
    wb(1'b1, REG_MASK, 32'h0000_0000);
    wb(1'b0, REG_STATUS, 32'h0);
    start(5'h10, 5'h00);
    first_grant("masked grant", 2'b01);
    repeat (2) @(posedge CLK_SYS);
    check("irq masked", 16'(irq), 16'h0000);
    wb(1'b1, REG_MASK, 32'h0000_0001);
    repeat (2) @(posedge CLK_SYS);
    check("irq raised", 16'(irq), 16'h0001);
    rchk("grant event", REG_STATUS, 16'h0001);
    repeat (2) @(posedge CLK_SYS);
    check("irq cleared", 16'(irq), 16'h0000);
    $display("interrupts done");
    report_and_stop();
  end
endmodule : bus_priority_arbiter_test
